//--- verilog/flash_guard_pkg.sv
package flash_guard_pkg;

   // ------------------------------------------------------------
   // flash geometry and fixed split
   // ------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [11:0] NO_READ_WHILE_WRITE_REGION_START = 12'hC00;
   localparam logic [11:0] APP_RESET_VEC = 12'h000;
   // boot start for each size code, largest boot part first
   localparam logic [11:0] BOOT_START_SZ0 = 12'hC00;
   localparam logic [11:0] BOOT_START_SZ1 = 12'hE00;
   localparam logic [11:0] BOOT_START_SZ2 = 12'hF00;
   localparam logic [11:0] BOOT_START_SZ3 = 12'hF80;

   // ------------------------------------------------------------
   // lock field layout, bit 1 is the upper bit
   // ------------------------------------------------------------
   localparam int LOCK_LO = 0;
   localparam int LOCK_HI = 1;
   localparam logic [1:0] LOCK_UNPROG = 2'h3;

   // ------------------------------------------------------------
   // register map, byte addresses on the avalon slave
   // ------------------------------------------------------------
   localparam int AV_ADDR_W = 4;
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_LOCK = 4'h4;
   localparam logic [3:0] REG_FUSE = 4'h8;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_ACTIVE_BIT = 1;
   localparam int ST_IVSEL_BIT = 2;
   localparam int LK_APP_LSB = 0;
   localparam int LK_BOOT_LSB = 2;
   localparam int FU_SIZE_LSB = 0;
   localparam int FU_RST_BIT = 2;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;

   // ------------------------------------------------------------
   // pin synchroniser vector layout
   // ------------------------------------------------------------
   localparam int SYNC_W = 13;
   localparam logic [1:0] LOAD_WAIT = 2'h2;

   typedef struct packed {
      logic [ADDR_W-1:0] fetch_addr;
      logic store_req;
      logic store_erase;
      logic [ADDR_W-1:0] store_addr;
      logic load_req;
      logic [ADDR_W-1:0] load_addr;
   } cpu_req_t;

   typedef struct packed {
      logic store_ok;
      logic store_refused;
      logic load_ok;
      logic load_refused;
      logic [15:0] load_data;
      logic halt;
      logic fetch_blocked;
      logic irq_mask;
      logic [ADDR_W-1:0] reset_vec;
   } cpu_rsp_t;

   typedef struct packed {
      logic start;
      logic erase;
      logic [ADDR_W-1:0] addr;
   } flash_cmd_t;

   function automatic logic [11:0] boot_start_f(input logic [1:0] sz);
      logic [11:0] s;
      unique case (sz)
         2'h0: s = BOOT_START_SZ0;
         2'h1: s = BOOT_START_SZ1;
         2'h2: s = BOOT_START_SZ2;
         default: s = BOOT_START_SZ3;
      endcase
      // never let the boot part reach below the fixed split
      return (s < NO_READ_WHILE_WRITE_REGION_START) ? NO_READ_WHILE_WRITE_REGION_START : s;
   endfunction : boot_start_f

   function automatic logic in_region_f(input logic [11:0] a,
                                        input logic [11:0] start);
      return a >= start;
   endfunction : in_region_f

   // modes 2 and 3 have the low bit programmed
   function automatic logic store_lock_f(input logic [1:0] f);
      return ~f[LOCK_LO];
   endfunction : store_lock_f

   // modes 3 and 4 have the high bit programmed
   function automatic logic load_lock_f(input logic [1:0] f);
      return ~f[LOCK_HI];
   endfunction : load_lock_f

endpackage : flash_guard_pkg

//--- verilog/lock_policy.sv
`timescale 1ns/100ps
module lock_policy
   import flash_guard_pkg::*;
(
   input wire logic fetch_boot_i,
   input wire logic store_boot_i,
   input wire logic load_boot_i,
   input wire logic [1:0] app_lock_i,
   input wire logic [1:0] boot_lock_i,
   input wire logic ivec_boot_i,
   output logic store_ok_o,
   output logic load_ok_o,
   output logic irq_mask_o
);

   // ------------------------------------------------------------
   // store permission
   // ------------------------------------------------------------
   // only boot code may program; target region lock decides the rest
   always_comb begin
      store_ok_o = fetch_boot_i &
         ~(store_boot_i ? store_lock_f(boot_lock_i)
                        : store_lock_f(app_lock_i));
   end

   // ------------------------------------------------------------
   // load permission, only cross-region reads are guarded
   // ------------------------------------------------------------
   always_comb begin
      if (fetch_boot_i && !load_boot_i) begin
         load_ok_o = ~load_lock_f(app_lock_i);
      end else if (!fetch_boot_i && load_boot_i) begin
         load_ok_o = ~load_lock_f(boot_lock_i);
      end else begin
         load_ok_o = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // interrupt masking while running in the shielded region
   // ------------------------------------------------------------
   always_comb begin
      irq_mask_o = (load_lock_f(app_lock_i) & ivec_boot_i
                    & ~fetch_boot_i)
                 | (load_lock_f(boot_lock_i) & ~ivec_boot_i
                    & fetch_boot_i);
   end

endmodule : lock_policy

//--- verilog/flash_guard.sv
// Functional notes
// - stores fetched from the application part never start programming
// - boot code stores may target any page, boot part included
// - boot size fuses set the split; each part has its own lock
// - rww page operation keeps cpu running, no_read_while_write_region fetches allowed
// - no_read_while_write_region page operation halts cpu for the whole operation
// - boot part always lies inside the no_read_while_write_region part
// - rww busy flag reads one while the rww part is blocked
// - two independent lock fields, each set without touching the other
// - locks set by software or programming pins, cleared by erase only
// - general chip locks do not affect flash stores or loads
// - bit 1 is unprogrammed; mode 1 leaves access unrestricted
// - app lock: modes 2,3 block stores, 3,4 block boot loads
// - app lock modes 3,4 mask irqs in app if vectors in boot
// - boot lock: modes 2,3 block stores, 3,4 block app loads
// - boot lock modes 3,4 mask irqs in boot if vectors in app
// - encodings 11 mode 1, 10 mode 2, 00 mode 3, 01 mode 4
// - reset vector is zero or boot start per boot reset fuse
`timescale 1ns/100ps
module flash_guard
   import flash_guard_pkg::*;
(
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic [AV_ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic [1:0] boot_size_fuses_i,
   input wire logic boot_reset_fuse_i,
   input wire logic [3:0] lock_nv_i,
   input wire logic ext_lock_wr_i,
   input wire logic [3:0] ext_lock_data_i,
   input wire logic chip_erase_i,
   input wire cpu_req_t cpu_req_i,
   output cpu_rsp_t cpu_rsp_o,
   input wire logic [15:0] flash_rdata_i,
   input wire logic prog_done_i,
   output flash_cmd_t flash_cmd_o,
   output logic [3:0] lock_nv_o
);

   // ------------------------------------------------------------
   // types and state
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_LOAD = 4'h1,
      ST_IDLE = 4'h2,
      ST_RWW_OP = 4'h4,
      ST_NO_READ_WHILE_WRITE_REGION_OP = 4'h8
   } guard_state_t;

   guard_state_t state_r;
   logic [SYNC_W-1:0] sync1_r;
   logic [SYNC_W-1:0] sync2_r;
   logic ext_wr_d_r;
   logic [1:0] load_cnt_r;
   logic [1:0] app_lock_r;
   logic [1:0] boot_lock_r;
   logic rww_busy_r;
   logic ivec_boot_r;
   logic ack_r;
   logic [31:0] rdata_r;
   logic store_ok_r;
   logic store_ref_r;
   logic load_ok_r;
   logic load_ref_r;
   logic [15:0] load_data_r;
   flash_cmd_t cmd_r;

   logic [1:0] size_s;
   logic rst_fuse_s;
   logic [3:0] nv_s;
   logic ext_wr_s;
   logic [3:0] ext_data_s;
   logic erase_s;
   logic [11:0] boot_start;
   logic fetch_boot;
   logic store_boot;
   logic load_boot;
   logic pol_store_ok;
   logic pol_load_ok;
   logic pol_irq_mask;
   logic av_req;
   logic av_take;
   logic sw_clear;
   logic sw_lock_wr;
   logic ext_lock_pulse;
   logic op_start;
   logic load_rww_blocked;
   logic [1:0] app_lock_nxt;
   logic [1:0] boot_lock_nxt;

   // ------------------------------------------------------------
   // pin synchroniser, two flops before any use
   // ------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else if (ce_i) begin
         sync1_r <= {chip_erase_i, ext_lock_data_i, ext_lock_wr_i,
                     lock_nv_i, boot_reset_fuse_i, boot_size_fuses_i};
         sync2_r <= sync1_r;
      end
   end

   assign size_s = sync2_r[1:0];
   assign rst_fuse_s = sync2_r[2];
   assign nv_s = sync2_r[6:3];
   assign ext_wr_s = sync2_r[7];
   assign ext_data_s = sync2_r[11:8];
   assign erase_s = sync2_r[12];

   // ------------------------------------------------------------
   // region decode
   // ------------------------------------------------------------
   assign boot_start = boot_start_f(size_s);
   assign fetch_boot = in_region_f(cpu_req_i.fetch_addr, boot_start);
   assign store_boot = in_region_f(cpu_req_i.store_addr, boot_start);
   assign load_boot = in_region_f(cpu_req_i.load_addr, boot_start);

   // general chip locks never enter this decision
   lock_policy u_policy (
      .fetch_boot_i(fetch_boot),
      .store_boot_i(store_boot),
      .load_boot_i(load_boot),
      .app_lock_i(app_lock_r),
      .boot_lock_i(boot_lock_r),
      .ivec_boot_i(ivec_boot_r),
      .store_ok_o(pol_store_ok),
      .load_ok_o(pol_load_ok),
      .irq_mask_o(pol_irq_mask)
   );

   // ------------------------------------------------------------
   // avalon slave, one wait state on every access
   // ------------------------------------------------------------
   assign av_req = avs_read_i | avs_write_i;
   assign av_take = av_req & ack_r;
   assign avs_waitrequest_o = av_req & ~ack_r;
   assign sw_clear = av_take & avs_write_i
      & (avs_address_i == REG_STATUS)
      & avs_writedata_i[ST_BUSY_BIT];
   assign sw_lock_wr = av_take & avs_write_i
      & (avs_address_i == REG_LOCK);

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ack_r <= 1'b0;
      end else if (ce_i) begin
         ack_r <= av_req & ~ack_r;
      end
   end

   // read data sampled in the wait cycle, unmapped reads give zero
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_r <= RD_ZERO;
      end else if (ce_i && avs_read_i && !ack_r) begin
         rdata_r <= RD_ZERO;
         unique case (avs_address_i)
            REG_STATUS: begin
               rdata_r[ST_BUSY_BIT] <= rww_busy_r;
               rdata_r[ST_ACTIVE_BIT] <= (state_r != ST_IDLE);
               rdata_r[ST_IVSEL_BIT] <= ivec_boot_r;
            end
            REG_LOCK: begin
               rdata_r[LK_APP_LSB +: 2] <= app_lock_r;
               rdata_r[LK_BOOT_LSB +: 2] <= boot_lock_r;
            end
            REG_FUSE: begin
               rdata_r[FU_SIZE_LSB +: 2] <= size_s;
               rdata_r[FU_RST_BIT] <= rst_fuse_s;
            end
            default: rdata_r <= RD_ZERO;
         endcase
      end
   end
   assign avs_readdata_o = rdata_r;

   // interrupt vector placement, plain software setting
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ivec_boot_r <= 1'b0;
      end else if (ce_i && av_take && avs_write_i
                   && avs_address_i == REG_STATUS) begin
         ivec_boot_r <= avs_writedata_i[ST_IVSEL_BIT];
      end
   end

   // ------------------------------------------------------------
   // lock fields: bits only go 1 to 0, chip erase restores 1
   // ------------------------------------------------------------
   always_comb begin
      app_lock_nxt = app_lock_r;
      boot_lock_nxt = boot_lock_r;
      if (sw_lock_wr) begin
         app_lock_nxt = app_lock_nxt
            & avs_writedata_i[LK_APP_LSB +: 2];
         boot_lock_nxt = boot_lock_nxt
            & avs_writedata_i[LK_BOOT_LSB +: 2];
      end
      if (ext_lock_pulse) begin
         app_lock_nxt = app_lock_nxt & ext_data_s[LK_APP_LSB +: 2];
         boot_lock_nxt = boot_lock_nxt & ext_data_s[LK_BOOT_LSB +: 2];
      end
   end
   assign ext_lock_pulse = ext_wr_s & ~ext_wr_d_r;

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ext_wr_d_r <= 1'b0;
      end else if (ce_i) begin
         ext_wr_d_r <= ext_wr_s;
      end
   end

   // nonvolatile copy is caught once the synchroniser has filled
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         app_lock_r <= LOCK_UNPROG;
         boot_lock_r <= LOCK_UNPROG;
      end else if (ce_i) begin
         if (erase_s) begin
            app_lock_r <= LOCK_UNPROG;
            boot_lock_r <= LOCK_UNPROG;
         end else if (state_r == ST_LOAD) begin
            app_lock_r <= nv_s[LK_APP_LSB +: 2];
            boot_lock_r <= nv_s[LK_BOOT_LSB +: 2];
         end else begin
            app_lock_r <= app_lock_nxt;
            boot_lock_r <= boot_lock_nxt;
         end
      end
   end
   assign lock_nv_o = {boot_lock_r, app_lock_r};

   // ------------------------------------------------------------
   // programming sequencer
   // ------------------------------------------------------------
   assign op_start = (state_r == ST_IDLE) & cpu_req_i.store_req
      & pol_store_ok;

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_r <= ST_LOAD;
         load_cnt_r <= 2'h0;
      end else if (ce_i) begin
         unique case (state_r)
            ST_LOAD: begin
               load_cnt_r <= load_cnt_r + 2'h1;
               if (load_cnt_r == LOAD_WAIT) begin
                  state_r <= ST_IDLE;
               end
            end
            ST_IDLE: begin
               if (op_start) begin
                  state_r <= in_region_f(cpu_req_i.store_addr,
                     NO_READ_WHILE_WRITE_REGION_START) ? ST_NO_READ_WHILE_WRITE_REGION_OP : ST_RWW_OP;
               end
            end
            ST_RWW_OP, ST_NO_READ_WHILE_WRITE_REGION_OP: begin
               if (prog_done_i) begin
                  state_r <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // busy flag: hardware set beats a software clear in the same cycle
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rww_busy_r <= 1'b0;
      end else if (ce_i) begin
         if (op_start && !in_region_f(cpu_req_i.store_addr,
                                      NO_READ_WHILE_WRITE_REGION_START)) begin
            rww_busy_r <= 1'b1;
         end else if (sw_clear && state_r != ST_RWW_OP) begin
            rww_busy_r <= 1'b0;
         end
      end
   end

   // command to the flash array, start is a one-cycle pulse
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cmd_r <= '0;
      end else if (ce_i) begin
         cmd_r.start <= op_start;
         if (op_start) begin
            cmd_r.erase <= cpu_req_i.store_erase;
            cmd_r.addr <= cpu_req_i.store_addr;
         end
      end
   end
   assign flash_cmd_o = cmd_r;

   // ------------------------------------------------------------
   // store and load answers to the cpu
   // ------------------------------------------------------------
   // loads from the rww part are refused while it is blocked
   assign load_rww_blocked = rww_busy_r
      & ~in_region_f(cpu_req_i.load_addr, NO_READ_WHILE_WRITE_REGION_START);

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         store_ok_r <= 1'b0;
         store_ref_r <= 1'b0;
      end else if (ce_i) begin
         store_ok_r <= op_start;
         store_ref_r <= cpu_req_i.store_req & ~op_start;
      end
   end

   // refused loads return zero, never the protected word
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         load_ok_r <= 1'b0;
         load_ref_r <= 1'b0;
         load_data_r <= 16'h0000;
      end else if (ce_i) begin
         load_ok_r <= cpu_req_i.load_req & pol_load_ok
            & ~load_rww_blocked;
         load_ref_r <= cpu_req_i.load_req
            & ~(pol_load_ok & ~load_rww_blocked);
         load_data_r <= (cpu_req_i.load_req && pol_load_ok
            && !load_rww_blocked) ? flash_rdata_i : 16'h0000;
      end
   end

   // outputs, halt follows state directly, fetch gating follows the rww busy flag
   always_comb begin
      cpu_rsp_o.store_ok = store_ok_r;
      cpu_rsp_o.store_refused = store_ref_r;
      cpu_rsp_o.load_ok = load_ok_r;
      cpu_rsp_o.load_refused = load_ref_r;
      cpu_rsp_o.load_data = load_data_r;
      cpu_rsp_o.halt = (state_r == ST_NO_READ_WHILE_WRITE_REGION_OP);
      cpu_rsp_o.fetch_blocked = rww_busy_r
         & ~in_region_f(cpu_req_i.fetch_addr, NO_READ_WHILE_WRITE_REGION_START);
      cpu_rsp_o.irq_mask = pol_irq_mask;
      cpu_rsp_o.reset_vec = rst_fuse_s ? APP_RESET_VEC
                                       : boot_start;
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   app_store_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      ce_i && cpu_req_i.store_req && !fetch_boot |=> !store_ok_r
         && store_ref_r)
      else $error("store from application part was accepted");

   boot_store_a: assert property (@(posedge mclk_i)
      disable iff (!nrst_i)
      ce_i && state_r == ST_IDLE && cpu_req_i.store_req && fetch_boot
      && boot_lock_r == LOCK_UNPROG && app_lock_r == LOCK_UNPROG
      |=> store_ok_r && cmd_r.start
         && cmd_r.addr == $past(cpu_req_i.store_addr))
      else $error("unlocked boot store was not started");

   boot_split_a: assert property (@(posedge mclk_i)
      disable iff (!nrst_i) boot_start >= NO_READ_WHILE_WRITE_REGION_START)
      else $error("boot part reaches below the no_read_while_write_region split");

   no_read_while_write_region_halt_a: assert property (@(posedge mclk_i)
      disable iff (!nrst_i)
      ce_i && op_start && in_region_f(cpu_req_i.store_addr, NO_READ_WHILE_WRITE_REGION_START)
      |=> cpu_rsp_o.halt)
      else $error("cpu not halted during no_read_while_write_region operation");

   no_read_while_write_region_hold_a: assert property (@(posedge mclk_i)
      disable iff (!nrst_i)
      ce_i && state_r == ST_NO_READ_WHILE_WRITE_REGION_OP && !prog_done_i |=> cpu_rsp_o.halt)
      else $error("cpu released before no_read_while_write_region operation ended");

   rww_run_a: assert property (@(posedge mclk_i)
      disable iff (!nrst_i)
      state_r == ST_RWW_OP |-> !cpu_rsp_o.halt && rww_busy_r
         && !(cpu_rsp_o.fetch_blocked
              && cpu_req_i.fetch_addr >= NO_READ_WHILE_WRITE_REGION_START))
      else $error("cpu stalled during rww operation");

   busy_flag_a: assert property (@(posedge mclk_i)
      disable iff (!nrst_i)
      $fell(rww_busy_r) |-> $past(sw_clear)
         && $past(state_r) != ST_RWW_OP)
      else $error("rww busy dropped without software clear");

   lock_sticky_a: assert property (@(posedge mclk_i)
      disable iff (!nrst_i)
      ce_i && !erase_s && state_r != ST_LOAD
      |=> ((app_lock_r & ~$past(app_lock_r)) == 2'h0)
         && ((boot_lock_r & ~$past(boot_lock_r)) == 2'h0))
      else $error("lock bit returned to unprogrammed");

   load_hidden_a: assert property (@(posedge mclk_i)
      disable iff (!nrst_i)
      load_ref_r |-> load_data_r == 16'h0000 && !load_ok_r)
      else $error("refused load returned data");

   reset_vec_a: assert property (@(posedge mclk_i)
      disable iff (!nrst_i)
      !rst_fuse_s |-> cpu_rsp_o.reset_vec == boot_start)
      else $error("reset vector ignores boot reset fuse");

endmodule : flash_guard

//--- tb/flash_model.sv
`timescale 1ns/100ps
// --------------------------
// flash array stand-in
// --------------------------
module flash_model
   import flash_guard_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire flash_cmd_t cmd_i,
   input wire logic ld_i,
   input wire logic [11:0] ld_addr_i,
   output logic done_o,
   output logic [15:0] rdata_o
);
   logic [4:0] cnt_r;
   // fixed page time, long enough to probe the busy window
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i)
         cnt_r <= 5'h00;
      else if (cmd_i.start)
         cnt_r <= 5'h14;
      else if (cnt_r != 5'h00)
         cnt_r <= cnt_r - 5'h01;
   end
   // idle bus drives 5A5 plus the page counter so stale data never passes for a read
   assign done_o = (cnt_r == 5'h01);
   assign rdata_o = ld_i ? {4'hA, ld_addr_i} : {11'h5A5, cnt_r};
endmodule : flash_model

//--- tb/testbench.sv
`timescale 1ns/100ps
module testbench
   import flash_guard_pkg::*;
;
   logic clk = 0, nrst = 0, rd = 0, wr = 0, ewr = 0, cer = 0;
   logic rf, done, wreq, bf;
   logic [1:0] sz, c;
   logic [3:0] adr = 4'h0, edat = 4'hF, v;
   logic [31:0] wd = 32'h0, rdat, q;
   logic [15:0] frd;
   logic [11:0] bs, aa, ba;
   cpu_req_t req = '0;
   cpu_rsp_t rsp;
   flash_cmd_t cmd;
   logic [19:0] expq [$];
   integer seed = 32'h2f45, bad_count = 0, n_tests = 0, cyc = 0;
   // --------------------------
   // clock, parts, checks
   // --------------------------
   initial forever #20 clk = ~clk;
   flash_guard u_dut (.mclk_i(clk), .nrst_i(nrst), .ce_i(1'b1),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wd), .avs_readdata_o(rdat),
      .avs_waitrequest_o(wreq), .boot_size_fuses_i(sz),
      .boot_reset_fuse_i(rf), .lock_nv_i(4'hF), .ext_lock_wr_i(ewr),
      .ext_lock_data_i(edat), .chip_erase_i(cer), .cpu_req_i(req),
      .cpu_rsp_o(rsp), .flash_rdata_i(frd), .prog_done_i(done),
      .flash_cmd_o(cmd), .lock_nv_o());
   flash_model u_flash (.clk_i(clk), .nrst_i(nrst), .cmd_i(cmd),
      .ld_i(req.load_req), .ld_addr_i(req.load_addr), .done_o(done),
      .rdata_o(frd));
   task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk_val
   task automatic chk_rsp(input logic [19:0] g, input logic [19:0] e);
      chk_val({12'h0, g}, {12'h0, e});
   endtask : chk_rsp
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : test_done
   // one avalon transfer; waits for waitrequest low
   task automatic av(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
      int k;
      k = 0;
      adr <= a;
      wd <= d;
      rd <= !w;
      wr <= w;
      do begin
         @(negedge clk);
         k++;
      end while (wreq && k < 50);
      @(posedge clk);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask : av
   // one store or load, expectation noted first
   task automatic cpu(input logic [11:0] f, input logic st,
                      input logic [11:0] a, input logic ok);
      req.fetch_addr <= f;
      req.store_req <= st;
      req.load_req <= !st;
      req.store_addr <= a;
      req.load_addr <= a;
      req.store_erase <= $random(seed);
      expq.push_back(st ? {ok, !ok, 18'h0} :
                     {2'h0, ok, !ok, ok ? {4'hA, a} : 16'h0});
      @(posedge clk);
      req.store_req <= 1'b0;
      req.load_req <= 1'b0;
      @(posedge clk);
   endtask : cpu
   task automatic wait_op(input logic h);
      int k;
      k = 0;
      while (done !== 1'b1 && k < 100) begin
         @(negedge clk);
         k++;
      end
      chk_val(rsp.halt, h);
      repeat (2) @(posedge clk);
      chk_val(rsp.halt, 0);
   endtask : wait_op
   // response watcher; data only matters on loads
   always @(negedge clk) begin
      if (rsp.store_ok | rsp.store_refused | rsp.load_ok | rsp.load_refused)
         chk_rsp({rsp.store_ok, rsp.store_refused, rsp.load_ok,
            rsp.load_refused, (rsp.load_ok | rsp.load_refused) ?
            rsp.load_data : 16'h0}, expq.pop_front());
   end
   // hang guard, far above the expected run length
   always @(posedge clk) begin
      cyc++;
      if (cyc > 5000) begin
         bad_count++;
         test_done();
      end
   end
   // --------------------------
   // main sequence
   // --------------------------
   initial begin
      sz = $random(seed);
      rf = $random(seed);
      bs = sz == 2'h0 ? BOOT_START_SZ0 : sz == 2'h1 ? BOOT_START_SZ1 :
           sz == 2'h2 ? BOOT_START_SZ2 : BOOT_START_SZ3;
      aa = {2'h0, 10'($random(seed))};
      ba = {5'h1F, 7'($random(seed))};
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      repeat (8) @(posedge clk);
      chk_val(rsp.reset_vec, rf ? APP_RESET_VEC : bs);
      av(0, REG_FUSE, 0);
      chk_val(q, {29'h0, rf, sz});
      av(0, REG_LOCK, 0);
      chk_val(q, 32'hF);
      av(1, 4'hC, 32'hFFFF);
      av(0, 4'hC, 0);
      chk_val(q, 0);
      $display("reset test done");
      cpu(12'h050, 1, aa, 0);
      cpu(12'hFC0, 1, ba, 1);
      wait_op(1);
      av(0, REG_STATUS, 0);
      chk_val(q[0], 0);
      cpu(12'hFC0, 1, aa, 1);
      req.fetch_addr <= aa;
      @(negedge clk);
      chk_val(rsp.fetch_blocked, 1);
      @(posedge clk);
      req.fetch_addr <= 12'hFC0;
      @(negedge clk);
      chk_val(rsp.fetch_blocked, 0);
      @(posedge clk);
      wait_op(0);
      av(0, REG_STATUS, 0);
      chk_val(q[0], 1);
      av(1, REG_STATUS, 1);
      cpu(12'hFC0, 0, aa, 1);
      $display("rww test done");
      // every code in each field; pin and bus programming alternate
      for (int i = 0; i < 8; i++) begin
         c = i[1:0];
         bf = i[2];
         v = bf ? {c, 2'h3} : {2'h3, c};
         cer <= 1'b1;
         repeat (4) @(posedge clk);
         cer <= 1'b0;
         repeat (4) @(posedge clk);
         if (i[0]) begin
            edat <= v;
            ewr <= 1'b1;
            repeat (4) @(posedge clk);
            ewr <= 1'b0;
            repeat (4) @(posedge clk);
         end else
            av(1, REG_LOCK, {28'h0, v});
         av(0, REG_LOCK, 0);
         chk_val(q, {28'h0, v});
         cpu(12'hFC0, 1, bf ? ba : aa, c[0]);
         if (c[0])
            wait_op(bf);
         av(1, REG_STATUS, {29'h0, !bf, 2'h1});
         cpu(bf ? 12'h050 : 12'hFC0, 0, bf ? ba : aa, c[1]);
         req.fetch_addr <= bf ? 12'hFC0 : 12'h050;
         @(negedge clk);
         chk_val(rsp.irq_mask, !c[1]);
         @(posedge clk);
         $display("lock test %0d done", i);
      end
      test_done();
   end
endmodule : testbench
